// file: src/tpc_pkg.sv
/*
  Shared constants and types of the table pair compare search block:
  register offsets, field positions, reset values, scan timing and the
  engine state type.
  Assumes a 125 MHz system clock and a 32-bit classic Wishbone bus.
*/
package tpc_pkg;

  // Data and address widths
  localparam int DW      = 16;            // Table word width
  localparam int MEM_AW  = 8;             // Table store address width
  localparam int WB_AW   = 12;            // Byte address width on the bus
  localparam int NUM_IDX = 10;            // Index registers 0..9

  // Register byte offsets
  localparam logic [WB_AW-1:0] OFF_CTRL     = 12'h000;
  localparam logic [WB_AW-1:0] OFF_STATUS   = 12'h004;
  localparam logic [WB_AW-1:0] OFF_BASE_A   = 12'h008;
  localparam logic [WB_AW-1:0] OFF_BASE_B   = 12'h00c;
  localparam logic [WB_AW-1:0] OFF_LEN      = 12'h010;
  localparam logic [WB_AW-1:0] OFF_PTR      = 12'h014;
  localparam logic [WB_AW-1:0] OFF_INT_STAT = 12'h018;
  localparam logic [WB_AW-1:0] OFF_INT_MASK = 12'h01c;
  localparam logic [WB_AW-1:0] OFF_IDX0     = 12'h020;
  localparam int               MEM_WIN_BIT  = 11;   // Table store window

  // Control register fields
  localparam int CB_EXEC     = 0;         // Compare control input
  localparam int CB_PULSE    = 1;         // Run on rising transition only
  localparam int CB_HEAD     = 2;         // Search from head
  localparam int CB_DIFF     = 3;         // 1 seeks unequal, 0 equal
  localparam int CF_SELA_LSB = 4;         // Index select for table A
  localparam int CF_SELB_LSB = 8;         // Index select for table B
  localparam int CF_SEL_W    = 4;

  // Status register fields
  localparam int SB_FOUND   = 0;
  localparam int SB_END     = 1;
  localparam int SB_ERR     = 2;
  localparam int SB_BUSY    = 3;
  localparam int SB_ENDSTOP = 4;

  // Interrupt status and mask fields
  localparam int IB_FOUND = 0;
  localparam int IB_END   = 1;
  localparam int IB_ERR   = 2;
  localparam int IB_DONE  = 3;
  localparam int IB_W     = 4;

  // Reset values
  localparam logic [DW-1:0] CTRL_RST = 16'h0ff0;   // No index offset
  localparam logic [DW-1:0] LEN_RST  = 16'h0002;
  localparam logic [DW-1:0] WORD_RST = 16'h0000;

  // Scan timing
  localparam int CLK_NS   = 8;
  localparam int SCAN_NS  = 1000;
  localparam int SCAN_CNT = SCAN_NS / CLK_NS;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_RDA,
    ST_RDB,
    ST_CMP
  } tpc_state_t;

endpackage

// file: src/tpc_mem_if.sv
/*
  Port between the search engine and its table store.
  Assumes one access per cycle and read data one cycle after the request.
*/
`timescale 1ns/1ns
interface tpc_mem_if #(
  parameter int AW = 8,
  parameter int DW = 16
);
  logic          en;
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport master (output en, output we, output addr, output wdata,
                  input rdata);
  modport mem    (input en, input we, input addr, input wdata,
                  output rdata);
endinterface

// file: src/tpc_table_mem.sv
/*
  Single-port table store holding both tables.
  Assumes the caller arbitrates; read data comes from a register one
  cycle after the request.
*/
`timescale 1ns/1ns
module tpc_table_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic clk_sys,
  tpc_mem_if.mem    mem
);

  logic [DW-1:0] store [2**AW];

  // Read first: a write returns the old word; read data registered
  always_ff @(posedge clk_sys) begin
    if (mem.en) begin
      if (mem.we) begin
        store[mem.addr] <= mem.wdata;
      end
      mem.rdata <= store[mem.addr];
    end
  end

endmodule

// file: src/tpc_compare_search.sv
/*
  Table pair compare search engine with a classic Wishbone register slave.
  Assumes a single 125 MHz clock, an asynchronous active-low reset and
  software that loads both tables through the table store window.
*/
// The implementer's own choices: the address map and the Wishbone slave port.
// Behaviour
// - Run while control set, or on rising edge
// - Head or pointer at end: start at pair zero
// - Otherwise start one past the current pointer
// - Polarity one seeks unequal, zero seeks equal
// - First hit stops, loads pointer, sets found
// - Last pair done: stop, end flag, pointer last
// - Run after end stop restarts from head
// - Pointer valid from zero to length minus one
// - Pointer out of range: error, no compare
// - Table bases offset by index registers 0-9
`timescale 1ns/1ns
module tpc_compare_search
  import tpc_pkg::*;
#(
  parameter int SCAN_CYCLES = SCAN_CNT
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  irq,
  output logic                  matchFoundFlag,
  output logic                  endFlag,
  output logic                  ptrErrFlag
);

  // Software registers
  logic [DW-1:0] ctrl_r;
  logic [DW-1:0] baseA_r;
  logic [DW-1:0] baseB_r;
  logic [DW-1:0] len_r;
  logic [DW-1:0] ptr_r;
  logic [DW-1:0] idx_r [NUM_IDX];
  logic [IB_W-1:0] intStat_r;
  logic [IB_W-1:0] intMask_r;

  // Engine state
  tpc_state_t    state_r;
  logic [DW-1:0] pos_r;
  logic [DW-1:0] dataA_r;
  logic          endStop_r;
  logic          trigPend_r;
  logic          execPrev_r;
  logic [15:0]   scanCnt_r;

  // Bus side
  logic          ack_r;
  logic [31:0]   datOut_r;
  logic          busPh_r;

  tpc_mem_if #(.AW(MEM_AW), .DW(DW)) memBus ();

  tpc_table_mem #(.AW(MEM_AW), .DW(DW)) uMem (
    .clk_sys (clk_sys),
    .mem     (memBus.mem)
  );

  // Decoded control fields
  logic                exec;
  logic                pulseMode;
  logic                fromHead;
  logic                seekDiff;
  logic [CF_SEL_W-1:0] selA;
  logic [CF_SEL_W-1:0] selB;

  assign exec      = ctrl_r[CB_EXEC];
  assign pulseMode = ctrl_r[CB_PULSE];
  assign fromHead  = ctrl_r[CB_HEAD];
  assign seekDiff  = ctrl_r[CB_DIFF];
  assign selA      = ctrl_r[CF_SELA_LSB +: CF_SEL_W];
  assign selB      = ctrl_r[CF_SELB_LSB +: CF_SEL_W];

  // Bus request decode; the guard on ack keeps one answer per request
  logic wbReq;
  logic isMem;
  logic regReq;
  logic regWr;
  logic busGrant;

  assign wbReq  = wb_cyc_i && wb_stb_i && !ack_r;
  assign isMem  = wb_adr_i[MEM_WIN_BIT];
  assign regReq = wbReq && !isMem;
  assign regWr  = regReq && wb_we_i;

  // Table store goes to the bus only while the engine rests
  assign busGrant = wbReq && isMem && !busPh_r && state_r == ST_IDLE
                    && !trigPend_r;

  // Index offsets for both bases; selects above nine add nothing
  logic [DW-1:0] offA;
  logic [DW-1:0] offB;

  always_comb begin
    offA = WORD_RST;
    offB = WORD_RST;
    if (selA < CF_SEL_W'(NUM_IDX)) begin
      offA = idx_r[selA];
    end
    if (selB < CF_SEL_W'(NUM_IDX)) begin
      offB = idx_r[selB];
    end
  end

  // Pair addresses; wrap inside the store by truncation
  logic [DW-1:0] sumA;
  logic [DW-1:0] sumB;

  assign sumA = baseA_r + offA + pos_r;
  assign sumB = baseB_r + offB + pos_r;

  // Pointer range and comparison result
  logic [DW-1:0] lastPos;
  logic          ptrValid;
  logic          hit;
  logic          atLast;

  assign lastPos  = len_r - 16'h0001;
  assign ptrValid = (len_r != WORD_RST) && (ptr_r <= lastPos);
  assign hit      = seekDiff ? (dataA_r != memBus.rdata)
                             : (dataA_r == memBus.rdata);
  assign atLast   = pos_r == lastPos;

  // Engine events, one cycle each
  logic evFound;
  logic evEnd;
  logic evErr;
  logic evDone;

  assign evFound = state_r == ST_CMP && hit;
  assign evEnd   = state_r == ST_CMP && !hit && atLast;
  assign evErr   = state_r == ST_START && !ptrValid;
  assign evDone  = evFound || evEnd || evErr;

  // Store port mux: engine reads A then B, otherwise the bus
  always_comb begin
    memBus.en    = 1'b0;
    memBus.we    = 1'b0;
    memBus.addr  = wb_adr_i[2 +: MEM_AW];
    memBus.wdata = wb_dat_i[DW-1:0];
    if (state_r == ST_RDA) begin
      memBus.en   = 1'b1;
      memBus.addr = sumA[MEM_AW-1:0];
    end else if (state_r == ST_RDB) begin
      memBus.en   = 1'b1;
      memBus.addr = sumB[MEM_AW-1:0];
    end else if (busGrant) begin
      memBus.en = 1'b1;
      memBus.we = wb_we_i && wb_sel_i[1:0] == 2'h3;
    end
  end

  // Scan divider: one evaluation chance per program scan
  logic scanTick;

  assign scanTick = scanCnt_r == 16'(SCAN_CYCLES - 1);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scanCnt_r <= 16'h0000;
    end else if (scanTick) begin
      scanCnt_r <= 16'h0000;
    end else begin
      scanCnt_r <= scanCnt_r + 16'h0001;
    end
  end

  // Trigger: level runs every scan, pulse mode only on a rising edge.
  // A trigger that meets a bus access to the store waits, not lost.
  logic trigNow;

  assign trigNow = scanTick && exec && (!pulseMode || !execPrev_r);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      execPrev_r <= 1'b0;
      trigPend_r <= 1'b0;
    end else begin
      if (scanTick) begin
        execPrev_r <= exec;
      end
      if (trigNow) begin
        trigPend_r <= 1'b1;
      end else if (state_r == ST_IDLE && !busPh_r) begin
        trigPend_r <= 1'b0;
      end
    end
  end

  // Search sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      pos_r   <= WORD_RST;
      dataA_r <= WORD_RST;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (trigPend_r && !busPh_r) begin
            state_r <= ST_START;
          end
        end
        ST_START: begin
          if (!ptrValid) begin
            state_r <= ST_IDLE;
          end else if (fromHead || endStop_r || ptr_r == lastPos) begin
            pos_r   <= WORD_RST;
            state_r <= ST_RDA;
          end else begin
            pos_r   <= ptr_r + 16'h0001;
            state_r <= ST_RDA;
          end
        end
        ST_RDA: begin
          state_r <= ST_RDB;
        end
        ST_RDB: begin
          dataA_r <= memBus.rdata;    // A word arrives as B is asked
          state_r <= ST_CMP;
        end
        ST_CMP: begin
          if (hit || atLast) begin
            state_r <= ST_IDLE;
          end else begin
            pos_r   <= pos_r + 16'h0001;
            state_r <= ST_RDA;
          end
        end
      endcase
    end
  end

  // Result flags: cleared as a run starts, set by its outcome
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      matchFoundFlag <= 1'b0;
      endFlag        <= 1'b0;
      ptrErrFlag     <= 1'b0;
      endStop_r      <= 1'b0;
    end else if (state_r == ST_START) begin
      matchFoundFlag <= 1'b0;
      endFlag        <= 1'b0;
      ptrErrFlag     <= !ptrValid;
      if (ptrValid) begin
        endStop_r <= 1'b0;
      end
    end else begin
      if (evFound) begin
        matchFoundFlag <= 1'b1;
      end
      if (evEnd) begin
        endFlag   <= 1'b1;
        endStop_r <= 1'b1;
      end
    end
  end

  // Pointer: the engine wins over a bus write in the same cycle.
  // Software must leave it alone while busy, or the write is lost when the run ends.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= WORD_RST;
    end else if (evFound) begin
      ptr_r <= pos_r;
    end else if (evEnd) begin
      ptr_r <= lastPos;
    end else if (state_r == ST_START && ptrValid
                 && (fromHead || endStop_r)) begin
      ptr_r <= WORD_RST;
    end else if (regWr && wb_adr_i == OFF_PTR) begin
      ptr_r <= wrMerge(ptr_r);
    end
  end

  // Byte-lane merge of a register write into a 16-bit register
  function automatic logic [DW-1:0] wrMerge(input logic [DW-1:0] old);
    logic [DW-1:0] v;
    v = old;
    if (wb_sel_i[0]) begin
      v[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      v[15:8] = wb_dat_i[15:8];
    end
    return v;
  endfunction

  // Plain configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= CTRL_RST;
      baseA_r   <= WORD_RST;
      baseB_r   <= WORD_RST;
      len_r     <= LEN_RST;
      intMask_r <= '0;
    end else if (regWr) begin
      unique case (wb_adr_i)
        OFF_CTRL:     ctrl_r    <= wrMerge(ctrl_r);
        OFF_BASE_A:   baseA_r   <= wrMerge(baseA_r);
        OFF_BASE_B:   baseB_r   <= wrMerge(baseB_r);
        OFF_LEN:      len_r     <= wrMerge(len_r);
        OFF_INT_MASK: begin
          if (wb_sel_i[0]) begin
            intMask_r <= wb_dat_i[IB_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Index registers, one word per entry
  for (genvar i = 0; i < NUM_IDX; i++) begin : gIdx
    localparam logic [WB_AW-1:0] OFF = OFF_IDX0 + WB_AW'(4 * i);
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        idx_r[i] <= WORD_RST;
      end else if (regWr && wb_adr_i == OFF) begin
        idx_r[i] <= wrMerge(idx_r[i]);
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear
  logic [IB_W-1:0] evVec;
  logic [IB_W-1:0] clrVec;

  always_comb begin
    evVec           = '0;
    evVec[IB_FOUND] = evFound;
    evVec[IB_END]   = evEnd;
    evVec[IB_ERR]   = evErr;
    evVec[IB_DONE]  = evDone;
    clrVec          = '0;
    if (regWr && wb_adr_i == OFF_INT_STAT && wb_sel_i[0]) begin
      clrVec = wb_dat_i[IB_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      intStat_r <= '0;
      irq       <= 1'b0;
    end else begin
      intStat_r <= (intStat_r & ~clrVec) | evVec;
      irq       <= |((intStat_r & ~clrVec | evVec) & intMask_r);
    end
  end

  // Register read mux; unmapped offsets read zero
  logic [31:0] regRdata;
  logic [DW-1:0] statWord;

  always_comb begin
    statWord             = WORD_RST;
    statWord[SB_FOUND]   = matchFoundFlag;
    statWord[SB_END]     = endFlag;
    statWord[SB_ERR]     = ptrErrFlag;
    statWord[SB_BUSY]    = state_r != ST_IDLE || trigPend_r;
    statWord[SB_ENDSTOP] = endStop_r;
    regRdata             = 32'h0000_0000;
    unique case (wb_adr_i)
      OFF_CTRL:     regRdata[DW-1:0]   = ctrl_r;
      OFF_STATUS:   regRdata[DW-1:0]   = statWord;
      OFF_BASE_A:   regRdata[DW-1:0]   = baseA_r;
      OFF_BASE_B:   regRdata[DW-1:0]   = baseB_r;
      OFF_LEN:      regRdata[DW-1:0]   = len_r;
      OFF_PTR:      regRdata[DW-1:0]   = ptr_r;
      OFF_INT_STAT: regRdata[IB_W-1:0] = intStat_r;
      OFF_INT_MASK: regRdata[IB_W-1:0] = intMask_r;
      default: begin
        for (int k = 0; k < NUM_IDX; k++) begin
          if (wb_adr_i == OFF_IDX0 + WB_AW'(4 * k)) begin
            regRdata[DW-1:0] = idx_r[k];
          end
        end
      end
    endcase
  end

  // Bus answer: registers in one cycle, table store in two once the engine rests and no trigger is pending
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_r    <= 1'b0;
      busPh_r  <= 1'b0;
      datOut_r <= 32'h0000_0000;
    end else begin
      ack_r <= 1'b0;
      if (busPh_r) begin
        busPh_r  <= 1'b0;
        ack_r    <= 1'b1;
        datOut_r <= {16'h0000, memBus.rdata};
      end else if (busGrant) begin
        busPh_r <= 1'b1;
      end else if (regReq) begin
        ack_r    <= 1'b1;
        datOut_r <= regRdata;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = datOut_r;

endmodule

// file: testbench/tpc_search_sva.sv
/*
  Checker for the compare search top: bus answer timing, read data shape,
  result flags and the interrupt line.
  Assumes a bind onto the top module and a single clock domain.
*/
`timescale 1ns/1ns
module tpc_search_sva
  import tpc_pkg::*;
#(
  parameter int SCAN_CYCLES = SCAN_CNT
) (
  input wire logic             clk_sys,
  input wire logic             rst_n,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             irq,
  input wire logic             matchFoundFlag,
  input wire logic             endFlag,
  input wire logic             ptrErrFlag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Result flags taken as one group
  wire logic [2:0] flags = {matchFoundFlag, endFlag, ptrErrFlag};

  // Store access waits at least one cycle, bounded by the longest run
  sequence s_store_wait;
    !wb_ack_o ##[1:1000] wb_ack_o;
  endsequence

  property p_reg_ack;
    $rose(wb_stb_i) && wb_cyc_i && !wb_adr_i[MEM_WIN_BIT] |=> wb_ack_o;
  endproperty
  a_reg_ack: assert property (p_reg_ack)
    else $error("register access not answered next cycle");

  property p_store_ack;
    $rose(wb_stb_i) && wb_cyc_i && wb_adr_i[MEM_WIN_BIT] |=> s_store_wait;
  endproperty
  a_store_ack: assert property (p_store_ack)
    else $error("store access answered too soon or never");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

  property p_rd_upper;
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("upper read half not zero");

  // Unmapped register offsets read as zero
  property p_unmapped;
    wb_ack_o && !wb_we_i && !wb_adr_i[MEM_WIN_BIT] && wb_adr_i >= 12'h048
      |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped offset read not zero");

  property p_flags_onehot;
    $onehot0(flags);
  endproperty
  a_flags_onehot: assert property (p_flags_onehot)
    else $error("more than one result flag set");

  // A compare result needs at least two cycles of cleared flags first
  property p_flags_clear;
    $rose(matchFoundFlag) || $rose(endFlag)
      |-> $past(flags, 1) == 3'h0 && $past(flags, 2) == 3'h0;
  endproperty
  a_flags_clear: assert property (p_flags_clear)
    else $error("result flag set without a clear first");

  // Sticky status only drops through a bus write; the write lands on the
  // edge that raises ack, so the line is seen low while ack is seen high
  property p_irq_fall;
    $fell(irq) |-> wb_ack_o && wb_we_i;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a write");
endmodule

// file: testbench/tpc_wb_master.sv
/*
  Software side of the register bus: classic Wishbone single cycles.
  Assumes the slave answers every request; the bench watchdog ends a hang.
*/
`timescale 1ns/1ns
module tpc_wb_master
  import tpc_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             ack,
  input  wire logic [31:0]      datIn,
  output logic                  cyc,
  output logic                  stb,
  output logic                  we,
  output logic      [WB_AW-1:0] adr,
  output logic      [3:0]       sel,
  output logic      [31:0]      datOut
);
  // Bus idle from time zero
  initial begin
    {cyc, stb, we, adr, sel, datOut} = '0;
  end

  // One cycle; request held until ack is sampled, no timing assumed
  task automatic xfer(input logic w, input logic [WB_AW-1:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    cyc    <= 1'b1;
    stb    <= 1'b1;
    we     <= w;
    adr    <= a;
    sel    <= 4'hf;
    datOut <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = datIn;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
endmodule

// file: testbench/table_pair_compare_search_tb_top.sv
/*
  Top bench of the compare search block: an integer model of the search
  is compared with the engine after every run.
  Assumes the package register map and a shortened scan tick.
*/
`timescale 1ns/1ns
module table_pair_compare_search_tb_top;
  import tpc_pkg::*;

  localparam int SCN = 8;   // Short tick keeps each run brief

  logic             clk_sys, rst_n, wbCyc, wbStb, wbWe, wbAck;
  logic [WB_AW-1:0] wbAdr;
  logic [3:0]       wbSel;
  logic [31:0]      wbDatW, wbDatR, rv;
  logic             irq, match_found_flag, endF, errF;
  int               failures, checksDone, len, mPtr, mStop, eF, eE, eR;
  int               ta [16];
  int               tb [16];

  tpc_compare_search #(.SCAN_CYCLES(SCN)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .irq(irq),
    .matchFoundFlag(match_found_flag), .endFlag(endF), .ptrErrFlag(errF));

  tpc_wb_master m (
    .clk_sys(clk_sys), .ack(wbAck), .datIn(wbDatR), .cyc(wbCyc),
    .stb(wbStb), .we(wbWe), .adr(wbAdr), .sel(wbSel), .datOut(wbDatW));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [WB_AW-1:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, rv);
  endtask

  task automatic rd(input logic [WB_AW-1:0] a, input logic [31:0] e);
    m.xfer(1'b0, a, 32'h0, rv);
    chk(rv, e);
  endtask

  task automatic test_done;
    if (failures == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Search model; an end stop is remembered until the next good run
  task automatic model(input int head, input int diff);
    int p;
    eF = 0;
    eE = 0;
    eR = (mPtr > len - 1);
    if (eR) return;
    p = (head || mStop || mPtr == len - 1) ? 0 : mPtr + 1;
    mStop = 0;
    forever begin
      if ((ta[p] != tb[p]) == diff) begin
        eF = 1;
        mPtr = p;
        break;
      end
      if (p == len - 1) begin
        eE = 1;
        mPtr = p;
        mStop = 1;
        break;
      end
      p++;
    end
  endtask

  // Pulse mode arms with exec low for a whole tick before raising it
  task automatic run(input int head, input int diff, input int lvl,
                     input logic [7:0] sel);
    logic [31:0] c;
    c = {20'h0, sel, diff[0], head[0], ~lvl[0], 1'b0};
    wr(OFF_INT_STAT, 32'hf);
    wr(OFF_CTRL, c);
    repeat (SCN + 2) @(posedge clk_sys);
    wr(OFF_CTRL, c | 32'h1);
    do m.xfer(1'b0, OFF_INT_STAT, 32'h0, rv);
    while (rv[IB_DONE] !== 1'b1);
    if (lvl) begin
      wr(OFF_CTRL, c);
      repeat (2 * SCN + 3 * len + 8) @(posedge clk_sys);
    end
    model(head, diff);
    chk({match_found_flag, endF, errF}, {eF[0], eE[0], eR[0]});
    rd(OFF_PTR, mPtr);
    rd(OFF_STATUS, {27'h0, mStop[0], 1'b0, eR[0], eE[0], eF[0]});
    chk(irq, 1'b0);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Watchdog well above the planned traffic
  initial begin
    #(8 * 20000);
    failures++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    {failures, checksDone, mPtr, mStop} = '0;
    void'($urandom(32'h6bee));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values, an unmapped place and the read-only status
    rd(OFF_CTRL, 32'h0ff0);
    rd(OFF_LEN, 32'h2);
    rd(OFF_PTR, 32'h0);
    rd(OFF_INT_MASK, 32'h0);
    wr(12'h048, 32'hffff);
    rd(12'h048, 32'h0);
    wr(OFF_STATUS, 32'h1f);
    rd(OFF_STATUS, 32'h0);
    // Random tables, about a third of the pairs equal
    len = 8 + $urandom % 8;
    wr(OFF_LEN, len);
    wr(OFF_BASE_A, 32'h20);
    wr(OFF_BASE_B, 32'h60);
    for (int i = 0; i < len; i++) begin
      ta[i] = $urandom % 65536;
      tb[i] = ($urandom % 3 == 0) ? ta[i] : ta[i] ^ (1 << ($urandom % 16));
      wr(12'h800 | 12'((32 + i) * 4), ta[i]);
      wr(12'h800 | 12'((96 + i) * 4), tb[i]);
    end
    // Store window read back takes the two-cycle answer path
    rd(12'h800 | 12'(32 * 4), ta[0]);
    rd(12'h800 | 12'((96 + len - 1) * 4), tb[len - 1]);
    mPtr = len - 1;
    wr(OFF_PTR, mPtr);
    // Both polarities, well past the table end, pointer moved between runs
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < len + 3; k++) begin
        if (!mStop && $urandom % 4 == 0) begin
          mPtr = ($urandom % 8 == 0) ? len + $urandom % 3 : $urandom % len;
          wr(OFF_PTR, mPtr);
        end
        run(($urandom % 6 == 0), d, 0, 8'hff);
      end
    end
    // Level control from the head, then bases offset by index registers
    run(1, 1, 1, 8'hff);
    wr(OFF_BASE_A, 32'h10);
    wr(OFF_IDX0 + 12'h8, 32'h10);
    wr(OFF_BASE_B, 32'h50);
    wr(OFF_IDX0 + 12'h1c, 32'h10);
    run(0, 0, 0, 8'h72);
    // Unmasked done raises the line; writing one to it drops it
    wr(OFF_INT_MASK, 32'h1 << IB_DONE);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    wr(OFF_INT_STAT, 32'h1 << IB_DONE);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    test_done();
  end
endmodule

bind tpc_compare_search tpc_search_sva #(.SCAN_CYCLES(SCAN_CYCLES)) u_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
  .matchFoundFlag(matchFoundFlag), .endFlag(endFlag),
  .ptrErrFlag(ptrErrFlag));
